// File: common/ntr_pkg.sv
// Package: register map, field layout and carriers of the tx count block
package ntr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] NTR_IDX_CNT_HI   = 6'h1d;
   localparam logic [5:0] NTR_IDX_CNT_LO   = 6'h1e;
   localparam logic [5:0] NTR_IDX_RATE     = 6'h1f;
   localparam logic [5:0] NTR_IDX_ADC      = 6'h20;
   localparam logic [5:0] NTR_IDX_TRIM_CTL = 6'h21;
   localparam logic [5:0] NTR_IDX_CAL_DISP = 6'h23;

   // Byte address field of haddr
   localparam int NTR_ADDR_LSB = 2;
   localparam int NTR_ADDR_MSB = 7;

   // Count field split between the two count registers
   localparam int NTR_CNT_W    = 13;
   localparam int NTR_CNT_LO_W = 5;
   localparam int NTR_SPLIT_W  = 3;

   // Field positions in the low count register
   localparam int NTR_CNT_LO_LSB = 3;
   localparam int NTR_CNT_LO_MSB = 7;
   localparam int NTR_SPLIT_MSB  = 2;

   // Field positions in the rate display register
   localparam int NTR_RATE_W   = 4;
   localparam int NTR_RATE_LSB = 4;
   localparam int NTR_RATE_MSB = 7;

   // Field positions in the trim control register
   localparam int NTR_TRIM_W   = 4;
   localparam int NTR_TRIM_SEL = 7;
   localparam int NTR_TRIM_LSB = 3;
   localparam int NTR_TRIM_MSB = 6;

   // Calibration display trim field position
   localparam int NTR_CAL_LSB = 4;
   localparam int NTR_CAL_MSB = 7;

   // Reset values and no-split code
   localparam logic [7:0]             NTR_RST_BYTE = 8'h00;
   localparam logic [NTR_SPLIT_W-1:0] NTR_NO_SPLIT = 3'h0;

   // AHB constants
   localparam logic [1:0] NTR_HTRANS_NONSEQ = 2'h2;
   localparam logic       NTR_HRESP_OKAY    = 1'b0;

   // One register access decoded by the bus slave
   typedef struct packed {
      logic       wr;    // Write strobe, data phase
      logic       rd;    // Read strobe, wait cycle
      logic       hit;   // Address inside the block window
      logic [5:0] idx;   // Register index
      logic [7:0] wdata; // Write byte
   } ntr_req_t;

   // Trim drive toward both trim pin groups
   typedef struct packed {
      logic [NTR_TRIM_W-1:0] grp1; // First trim pin group
      logic [NTR_TRIM_W-1:0] grp2; // Second trim pin group
   } ntr_trim_t;

endpackage : ntr_pkg

// File: hdl/ntr_ahb_slave.sv
// AHB-Lite slave front end: address capture and access strobes
module ntr_ahb_slave
   import ntr_pkg::*;
(
   input  wire logic        clk,       // System clock
   input  wire logic        rst_n,     // Synchronous reset, active low
   input  wire logic        hsel,      // Slave select
   input  wire logic [31:0] haddr,     // Byte address
   input  wire logic [1:0]  htrans,    // Transfer type
   input  wire logic        hwrite,    // Write not read
   input  wire logic        hready,    // Bus ready
   input  wire logic [31:0] hwdata,    // Write data
   output logic             hreadyout, // Slave ready
   output ntr_req_t         req        // Decoded access
);

   logic       wr_pend_q;  // Write data phase pending
   logic       rd_pend_q;  // Read wait cycle pending
   logic       hit_q;      // Captured address in window
   logic [5:0] idx_q;      // Captured register index
   logic       rdy_q;      // Ready toward the bus
   logic       take;       // Address phase accepted

   // Accept a NONSEQ address phase when the bus is ready
   assign take = hsel && hready && (htrans == NTR_HTRANS_NONSEQ);

   // Address phase capture
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         hit_q     <= 1'b0;
         idx_q     <= '0;
      end else begin
         wr_pend_q <= take && hwrite;
         rd_pend_q <= take && !hwrite;
         if (take) begin
            // Upper address bits must be zero to hit
            hit_q <= (haddr[31:NTR_ADDR_MSB+1] == '0);
            idx_q <= haddr[NTR_ADDR_MSB:NTR_ADDR_LSB];
         end
      end
   end

   // Reads take one wait cycle so a prior write is seen
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdy_q <= 1'b1;
      end else begin
         rdy_q <= !(take && !hwrite);
      end
   end

   assign hreadyout = rdy_q;

   // Strobes toward the register file
   always_comb begin
      req.wr    = wr_pend_q;
      req.rd    = rd_pend_q;
      req.hit   = hit_q;
      req.idx   = idx_q;
      req.wdata = hwdata[7:0];
   end

endmodule : ntr_ahb_slave

// File: hdl/ntr_regs.sv
// Tx byte count, split bits, rate, converter and antenna trim registers
//
// Contract
// - Hold 13-bit tx byte count, split across registers
// - Three split bits; zero means no split
// - Split bits apply to anticollision partial frames (split flags here ignore anticoll_ctl)
// - Split byte transmits without parity generation
// - Idle anticollision split WUPA raises parity error
// - Rate register shows 4-bit detected bit rate
// - Converter register shows last conversion, read-only
// - Trim select picks calibration or manual bits
// - Manual trim bit on drives both groups
// - Writable registers reset and restore to zero
// - Read-only registers reset and restore to zero
// - Calibration result stored, drives automatic trim
//
// Chosen here: register access over AHB-Lite.
module ntr_regs
   import ntr_pkg::*;
(
   input  wire logic                   clk,            // 10 MHz clock
   input  wire logic                   rst_n,          // Sync reset, low
   // AHB-Lite register port
   input  wire logic                   hsel,           // Slave select
   input  wire logic [31:0]            haddr,          // Byte address
   input  wire logic [1:0]             htrans,         // Transfer type
   input  wire logic                   hwrite,         // Write not read
   input  wire logic [2:0]             hsize,          // Transfer size
   input  wire logic                   hready,         // Bus ready
   input  wire logic [31:0]            hwdata,         // Write data
   output logic [31:0]                 hrdata,         // Read data
   output logic                        hreadyout,      // Slave ready
   output logic                        hresp,          // Always OKAY
   // Device side, same clock domain
   input  wire logic                   restore_dflt,   // Restore pulse
   input  wire logic                   rate_valid,     // Rate result pulse
   input  wire logic [NTR_RATE_W-1:0]  rate_value,     // Detected rate
   input  wire logic                   adc_valid,      // Conversion done
   input  wire logic [7:0]             adc_value,      // Conversion result
   input  wire logic                   cal_valid,      // Calibration done
   input  wire logic [NTR_TRIM_W-1:0]  cal_value,      // Calibration trim
   input  wire logic                   cal_error,      // Calibration failed
   input  wire logic                   anticoll_ctl,   // Anticollision bit
   input  wire logic                   card_idle,      // Card in idle state
   input  wire logic                   wupa_cmd,       // WUPA issued pulse
   output logic [NTR_CNT_W-1:0]        tx_byte_cnt,    // Full bytes to send
   output logic [NTR_SPLIT_W-1:0]      tx_split_bits,  // Bits of split byte
   output logic                        tx_split_frame, // Partial last byte
   output logic                        tx_parity_off,  // No parity bits
   output logic                        parity_err_irq, // Parity error pulse
   output ntr_trim_t                   trim_drive      // Trim switch drive
);

   // Decoded bus access
   ntr_req_t req;

   // Register state
   logic [NTR_CNT_W-1:0]   cnt_q;       // Full byte count
   logic [NTR_SPLIT_W-1:0] split_q;     // Split byte bit count
   logic [NTR_RATE_W-1:0]  rate_q;      // Detected bit rate
   logic [7:0]             adc_q;       // Last conversion
   logic                   trim_sel_q;  // Manual trim select
   logic [NTR_TRIM_W-1:0]  trim_man_q;  // Manual trim bits
   logic [NTR_TRIM_W-1:0]  cal_trim_q;  // Stored calibration trim
   logic                   cal_err_q;   // Calibration error flag

   // Output flops
   logic [31:0]            hrdata_q;    // Read data
   logic                   split_frm_q; // Split frame flag
   logic                   par_off_q;   // Parity generation off
   logic                   par_irq_q;   // Parity error pulse
   ntr_trim_t              trim_q;      // Trim pin drive

   // Clear condition for every register except the read data flop
   logic                   clr;
   // Register write strobes
   logic                   wr_hi;
   logic                   wr_lo;
   logic                   wr_trim;

   // Hit test on a captured register index
   function automatic logic idx_is(input ntr_req_t r,
                                   input logic [5:0] idx);
      idx_is = r.hit && (r.idx == idx);
   endfunction : idx_is

   // Place a field into an otherwise zero byte
   function automatic logic [7:0] pack_field(input logic [7:0] val,
                                             input int         lsb);
      pack_field = 8'(val << lsb);
   endfunction : pack_field

   // Bus slave front end
   ntr_ahb_slave u_slave (
      .clk       (clk),
      .rst_n     (rst_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hwdata    (hwdata),
      .hreadyout (hreadyout),
      .req       (req)
   );

   // Reset and restore-defaults both clear the bank
   assign clr = !rst_n || restore_dflt;

   // Write strobes per register
   assign wr_hi   = req.wr && idx_is(req, NTR_IDX_CNT_HI);
   assign wr_lo   = req.wr && idx_is(req, NTR_IDX_CNT_LO);
   assign wr_trim = req.wr && idx_is(req, NTR_IDX_TRIM_CTL);

   // Upper eight bits of the byte count
   always_ff @(posedge clk) begin
      if (clr) begin
         cnt_q[NTR_CNT_W-1:NTR_CNT_LO_W] <= NTR_RST_BYTE;
      end else if (wr_hi) begin
         // Host keeps the count within 8191, the field width
         cnt_q[NTR_CNT_W-1:NTR_CNT_LO_W] <= req.wdata;
      end
   end

   // Lower five count bits and split bit count
   always_ff @(posedge clk) begin
      if (clr) begin
         cnt_q[NTR_CNT_LO_W-1:0] <= '0;
         split_q                 <= NTR_NO_SPLIT;
      end else if (wr_lo) begin
         // Count bits sit above the split field
         cnt_q[NTR_CNT_LO_W-1:0] <=
            req.wdata[NTR_CNT_LO_MSB:NTR_CNT_LO_LSB];
         split_q <= req.wdata[NTR_SPLIT_MSB:0];
      end
   end

   // Detected bit rate display, updated by the detector
   always_ff @(posedge clk) begin
      if (clr) begin
         rate_q <= '0;
      end else if (rate_valid) begin
         rate_q <= rate_value;
      end
   end

   // Converter output display, bus writes never touch it
   always_ff @(posedge clk) begin
      if (clr) begin
         adc_q <= NTR_RST_BYTE;
      end else if (adc_valid) begin
         adc_q <= adc_value;
      end
   end

   // Trim control: source select and manual bits
   always_ff @(posedge clk) begin
      if (clr) begin
         trim_sel_q <= 1'b0;
         trim_man_q <= '0;
      end else if (wr_trim) begin
         // Low three bits are unused and dropped
         trim_sel_q <= req.wdata[NTR_TRIM_SEL];
         trim_man_q <= req.wdata[NTR_TRIM_MSB:NTR_TRIM_LSB];
      end
   end

   // Calibration result store, read back on the display index
   always_ff @(posedge clk) begin
      if (clr) begin
         cal_trim_q <= '0;
         cal_err_q  <= 1'b0;
      end else if (cal_valid) begin
         cal_trim_q <= cal_value;
         cal_err_q  <= cal_error;
      end
   end

   // Trim switch drive: both pin groups follow the chosen source
   always_ff @(posedge clk) begin
      if (clr) begin
         trim_q <= '0;
      end else if (trim_sel_q) begin
         // Manual bits, most significant bit on the top switch
         trim_q.grp1 <= trim_man_q;
         trim_q.grp2 <= trim_man_q;
      end else begin
         // Stored calibration result
         trim_q.grp1 <= cal_trim_q;
         trim_q.grp2 <= cal_trim_q;
      end
   end

   // Split-frame flags toward the framer
   always_ff @(posedge clk) begin
      if (clr) begin
         split_frm_q <= 1'b0;
         par_off_q   <= 1'b0;
      end else begin
         // Nonzero split count marks a partial frame, anticollision or not
         split_frm_q <= (split_q != NTR_NO_SPLIT);
         // Partial last byte goes out with no parity bits
         par_off_q   <= (split_q != NTR_NO_SPLIT);
      end
   end

   // Parity error on WUPA in idle with split bits set
   always_ff @(posedge clk) begin
      if (clr) begin
         par_irq_q <= 1'b0;
      end else begin
         par_irq_q <= wupa_cmd && anticoll_ctl && card_idle &&
                      (split_q != NTR_NO_SPLIT);
      end
   end

   // Read data, loaded in the wait cycle of a read
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hrdata_q <= '0;
      end else if (req.rd) begin
         // Unmapped or out-of-window reads return zero
         hrdata_q <= '0;
         if (idx_is(req, NTR_IDX_CNT_HI)) begin
            hrdata_q[7:0] <= cnt_q[NTR_CNT_W-1:NTR_CNT_LO_W];
         end else if (idx_is(req, NTR_IDX_CNT_LO)) begin
            hrdata_q[7:0] <=
               pack_field(8'(cnt_q[NTR_CNT_LO_W-1:0]), NTR_CNT_LO_LSB) |
               8'(split_q);
         end else if (idx_is(req, NTR_IDX_RATE)) begin
            // Low nibble unused, reads zero
            hrdata_q[7:0] <=
               pack_field(8'(rate_q), NTR_RATE_LSB);
         end else if (idx_is(req, NTR_IDX_ADC)) begin
            hrdata_q[7:0] <= adc_q;
         end else if (idx_is(req, NTR_IDX_TRIM_CTL)) begin
            hrdata_q[7:0] <=
               pack_field(8'(trim_sel_q), NTR_TRIM_SEL) |
               pack_field(8'(trim_man_q), NTR_TRIM_LSB);
         end else if (idx_is(req, NTR_IDX_CAL_DISP)) begin
            hrdata_q[7:0] <=
               pack_field(8'(cal_trim_q), NTR_CAL_LSB) |
               pack_field(8'(cal_err_q), NTR_TRIM_LSB);
         end
      end
   end

   // Output assignments, all straight from flops except the constant hresp
   assign hrdata         = hrdata_q;
   assign hresp          = NTR_HRESP_OKAY;
   assign tx_byte_cnt    = cnt_q;
   assign tx_split_bits  = split_q;
   assign tx_split_frame = split_frm_q;
   assign tx_parity_off  = par_off_q;
   assign parity_err_irq = par_irq_q;
   assign trim_drive     = trim_q;

   // Transfer size is not checked; only word accesses are expected
   logic unused_hsize;
   assign unused_hsize = ^hsize;

endmodule : ntr_regs

// File: testbench/ntr_regs_asserts.sv
// Checker: bus timing, tx flags, interrupt and trim drive properties
module ntr_regs_chk
   import ntr_pkg::*;
(
   input wire logic        clk,            // Clock
   input wire logic        rst_n,          // Reset, low
   input wire logic        hsel,           // Select
   input wire logic [1:0]  htrans,         // Transfer type
   input wire logic        hwrite,         // Write
   input wire logic        hready,         // Bus ready
   input wire logic        hreadyout,      // Slave ready
   input wire logic        restore_dflt,   // Restore pulse
   input wire logic        anticoll_ctl,   // Anticollision bit
   input wire logic        card_idle,      // Card idle
   input wire logic        wupa_cmd,       // WUPA pulse
   input wire logic [12:0] tx_byte_cnt,    // Byte count
   input wire logic [2:0]  tx_split_bits,  // Split bits
   input wire logic        tx_split_frame, // Partial frame
   input wire logic        tx_parity_off,  // No parity
   input wire logic        parity_err_irq, // Parity error
   input wire ntr_trim_t   trim_drive      // Trim drive
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Address phases taken by the slave
   sequence s_take_rd;
      hsel && hready && htrans == NTR_HTRANS_NONSEQ && !hwrite;
   endsequence
   sequence s_take_wr;
      hsel && hready && htrans == NTR_HTRANS_NONSEQ && hwrite;
   endsequence
   // Read data phase: one wait, then ready
   sequence s_rd_phase;
      !hreadyout ##1 hreadyout;
   endsequence
   chk_read_wait: assert property (s_take_rd |=> s_rd_phase)
      else $error("read data phase not one wait state");
   chk_write_nowait: assert property (s_take_wr |=> hreadyout)
      else $error("write data phase stalled");
   chk_split_flags: assert property (!restore_dflt |=>
      tx_split_frame == ($past(tx_split_bits) != NTR_NO_SPLIT)
      && tx_parity_off == tx_split_frame)
      else $error("split frame or parity flag wrong");
   chk_irq_raise: assert property (wupa_cmd && anticoll_ctl && card_idle
      && tx_split_bits != NTR_NO_SPLIT && !restore_dflt |=> parity_err_irq)
      else $error("parity error not raised on WUPA");
   chk_irq_cause: assert property (parity_err_irq |-> $past(wupa_cmd))
      else $error("parity error without WUPA");
   chk_trim_groups: assert property (trim_drive.grp1 == trim_drive.grp2)
      else $error("trim groups differ");
   chk_restore_clear: assert property (restore_dflt |=>
      tx_byte_cnt == '0 && tx_split_bits == '0 ##1 trim_drive == '0)
      else $error("restore left state set");
   chk_reset_clear: assert property ($rose(rst_n) |->
      tx_byte_cnt == '0 && !parity_err_irq && trim_drive == '0)
      else $error("reset left state set");
endmodule : ntr_regs_chk

bind ntr_regs ntr_regs_chk u_chk (.clk, .rst_n, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .restore_dflt, .anticoll_ctl, .card_idle, .wupa_cmd,
   .tx_byte_cnt, .tx_split_bits, .tx_split_frame, .tx_parity_off,
   .parity_err_irq, .trim_drive);

// File: testbench/ntr_host_model.sv
// Host model: AHB-Lite master issuing single word transfers
module ntr_host_model
   import ntr_pkg::*;
(
   input  wire logic        clk,    // Clock
   input  wire logic        hready, // Bus ready
   input  wire logic [31:0] hrdata, // Read data
   output logic             hsel,   // Select
   output logic [31:0]      haddr,  // Byte address
   output logic [1:0]       htrans, // Transfer type
   output logic             hwrite, // Write not read
   output logic [2:0]       hsize,  // Word size
   output logic [31:0]      hwdata  // Write data
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end
   // Address phase held until taken, then released and scrambled
   task automatic addr(input logic [5:0] idx, input logic wr);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, idx, 2'b00};
      htrans <= NTR_HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~haddr;
   endtask : addr
   // Single word write, data held until ready
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      addr(idx, 1'b1);
      hwdata <= {24'h00_0000, d};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hwdata <= ~hwdata;
   endtask : wr
   // Single word read, data taken at the ready edge
   task automatic rd(input logic [5:0] idx, output logic [31:0] d);
      addr(idx, 1'b0);
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      d = hrdata;
   endtask : rd
endmodule : ntr_host_model

// File: testbench/tb.sv
// Testbench: register bank scenarios through the host model
module tb;
   import ntr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0]  htrans;
   logic [2:0]  hsize, tx_split_bits;
   logic        restore_dflt, rate_valid, adc_valid, cal_valid, cal_error;
   logic        anticoll_ctl, card_idle, wupa_cmd, parity_err_irq;
   logic [3:0]  rate_value, cal_value;
   logic [7:0]  adc_value;
   logic [12:0] tx_byte_cnt;
   logic        tx_split_frame, tx_parity_off;
   ntr_trim_t   trim_drive;
   int          fails, n_tests, cyc;

   ntr_host_model u_host (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata);
   ntr_regs u_ntr_regs (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .restore_dflt,
      .rate_valid, .rate_value, .adc_valid, .adc_value, .cal_valid, .cal_value,
      .cal_error, .anticoll_ctl, .card_idle, .wupa_cmd, .tx_byte_cnt,
      .tx_split_bits, .tx_split_frame, .tx_parity_off, .parity_err_irq,
      .trim_drive);

   // Compare and count
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Read a register and compare its byte
   task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
      u_host.rd(idx, rdv);
      cmp(rdv, {24'h00_0000, exp});
   endtask : rdchk
   // Let outputs settle after n edges
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // Five registers, count, split bits and trim drive back at zero
   task automatic all_zero();
      rdchk(NTR_IDX_CNT_HI, 8'h00);
      rdchk(NTR_IDX_CNT_LO, 8'h00);
      rdchk(NTR_IDX_RATE, 8'h00);
      rdchk(NTR_IDX_ADC, 8'h00);
      rdchk(NTR_IDX_TRIM_CTL, 8'h00);
      tick(1);
      cmp({8'h0, tx_byte_cnt, tx_split_bits, trim_drive}, 32'h0);
      cmp({31'h0, hresp}, {31'h0, NTR_HRESP_OKAY});
   endtask : all_zero
   // WUPA pulse and parity error check one edge later
   task automatic wupa(input logic exp);
      @(posedge clk);
      wupa_cmd <= 1'b1;
      @(posedge clk);
      wupa_cmd <= 1'b0;
      #1;
      cmp({31'h0, parity_err_irq}, {31'h0, exp});
   endtask : wupa
   // Maximum count with split byte, then no split
   task automatic t_count();
      u_host.wr(NTR_IDX_CNT_HI, 8'hff);
      u_host.wr(NTR_IDX_CNT_LO, 8'hfd);
      tick(2);
      cmp({19'h0, tx_byte_cnt}, 32'd8191);
      cmp({29'h0, tx_split_bits}, 32'h5);
      cmp({30'h0, tx_split_frame, tx_parity_off}, 32'h3);
      rdchk(NTR_IDX_CNT_LO, 8'hfd);
      u_host.wr(NTR_IDX_CNT_LO, 8'h08);
      tick(2);
      cmp({19'h0, tx_byte_cnt}, 32'h1fe1);
      cmp({30'h0, tx_split_frame, tx_parity_off}, 32'h0);
   endtask : t_count
   // Parity error only with idle card and split, anticollision held on
   task automatic t_irq();
      u_host.wr(NTR_IDX_CNT_LO, 8'h03);
      anticoll_ctl <= 1'b1;
      card_idle <= 1'b1;
      wupa(1'b1);
      card_idle <= 1'b0;
      wupa(1'b0);
      card_idle <= 1'b1;
      u_host.wr(NTR_IDX_CNT_LO, 8'h00);
      wupa(1'b0);
   endtask : t_irq
   // Status loads hold, bus writes ignored
   task automatic t_status();
      @(posedge clk);
      rate_valid <= 1'b1;
      rate_value <= 4'ha;
      adc_valid <= 1'b1;
      adc_value <= 8'h5c;
      @(posedge clk);
      rate_valid <= 1'b0;
      adc_valid <= 1'b0;
      rate_value <= 4'h5;
      adc_value <= 8'ha3;
      u_host.wr(NTR_IDX_RATE, 8'hff);
      rdchk(NTR_IDX_RATE, 8'ha0);
      u_host.wr(NTR_IDX_ADC, 8'hff);
      rdchk(NTR_IDX_ADC, 8'h5c);
   endtask : t_status
   // Automatic trim from calibration, manual trim, unmapped read
   task automatic t_trim();
      @(posedge clk);
      cal_valid <= 1'b1;
      cal_value <= 4'h9;
      cal_error <= 1'b1;
      @(posedge clk);
      cal_valid <= 1'b0;
      cal_value <= 4'h6;
      cal_error <= 1'b0;
      tick(2);
      cmp({24'h0, trim_drive}, 32'h99);
      rdchk(NTR_IDX_CAL_DISP, 8'h98);
      u_host.wr(NTR_IDX_TRIM_CTL, 8'hb7);
      tick(2);
      cmp({24'h0, trim_drive}, 32'h66);
      rdchk(NTR_IDX_TRIM_CTL, 8'hb0);
      u_host.wr(NTR_IDX_TRIM_CTL, 8'h30);
      tick(2);
      cmp({24'h0, trim_drive}, 32'h99);
      rdchk(6'h3f, 8'h00);
   endtask : t_trim
   // Restore pulse clears every register
   task automatic t_restore();
      u_host.wr(NTR_IDX_CNT_LO, 8'h0f);
      @(posedge clk);
      restore_dflt <= 1'b1;
      @(posedge clk);
      restore_dflt <= 1'b0;
      all_zero();
      rdchk(NTR_IDX_CAL_DISP, 8'h00);
   endtask : t_restore
   // Counts, verdict and end of run
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   // Clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         results();
      end
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      {restore_dflt, rate_valid, adc_valid, cal_valid, cal_error} = 5'h00;
      {anticoll_ctl, card_idle, wupa_cmd} = 3'h0;
      {rate_value, cal_value, adc_value} = 16'h0000;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      all_zero();
      t_count();
      t_irq();
      t_status();
      t_trim();
      t_restore();
      results();
   end
endmodule : tb
